// [verilog/cds_params.svh]
`ifndef CDS_PARAMS_SVH
`define CDS_PARAMS_SVH

// Register offsets on the internal register port (13-bit addresses).
`define CDS_ADDR_W 13
`define CDS_ADDR_ALIGN 13'h109
`define CDS_ADDR_POWER 13'h008
`define CDS_ADDR_STAB 13'h009
`define CDS_ADDR_RATIO 13'h10B
`define CDS_ADDR_STATUS 13'h10C

// Field positions in the divider alignment register.
`define CDS_ALIGN_EN_BIT 0
`define CDS_ALIGN_ONCE_BIT 1
`define CDS_ALIGN_SYSREF_BIT 7
`define CDS_ALIGN_MASK 8'h83

// Field positions in the power, stabilizer and ratio registers.
`define CDS_POWER_PD_BIT 0
`define CDS_POWER_STBY_BIT 1
`define CDS_POWER_MASK 8'h03
`define CDS_STAB_EN_BIT 0
`define CDS_STAB_MASK 8'h01
`define CDS_RATIO_MASK 8'h07

// Field positions in the status register.
`define CDS_STAT_ARMED_BIT 0
`define CDS_STAT_PD_BIT 1
`define CDS_STAT_STBY_BIT 2
`define CDS_STAT_READY_BIT 3
`define CDS_STAT_PIN_BIT 4

// Reset values.
`define CDS_RST_ALIGN 8'h00
`define CDS_RST_POWER 8'h00
`define CDS_RST_STAB 8'h01
`define CDS_RST_RATIO 8'h00
`define CDS_RDATA_NONE 8'h00

// Standby keeps the reference charged, so its wake time is the
// down time shifted right by this many places.
`define CDS_STBY_WAKE_SHIFT 2

`endif

// [verilog/cds_pkg.sv]
package cds_pkg;

	// One access on the internal register port behind the serial control port.
	typedef struct packed {
		logic wr; // Write strobe, one cycle.
		logic rd; // Read strobe, one cycle.
		logic [12:0] addr; // Register offset.
		logic [7:0] wdata; // Write data.
	} cds_reg_req_t;

	// Asynchronous control pins, sampled together.
	typedef struct packed {
		logic sync_strobe; // External divider alignment strobe.
		logic sysref; // SYSREF from the link clocking.
		logic powerdown_pin; // High requests power-down.
	} cds_pins_t;

	// Power state of the converter core.
	typedef enum logic [1:0] {
		CDS_PWR_RUN,
		CDS_PWR_DOWN,
		CDS_PWR_STBY,
		CDS_PWR_WAKE
	} cds_pwr_state_t;

endpackage

// [verilog/cds_sync2.sv]
module cds_sync2 #(
	parameter int WIDTH = 3
) (
	input wire logic core_clk, // Sample clock.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic [WIDTH-1:0] async_in, // Pins from outside the clock domain.
	output logic [WIDTH-1:0] sync_out // Two-flop synchronised copies.
);

	////////////////////////////////////////////////////////////////////////
	// Elaboration check.
	if (WIDTH < 1) begin : g_chk
		$error("cds_sync2 needs WIDTH of at least one.");
	end

	////////////////////////////////////////////////////////////////////////
	// One two-stage synchroniser per bit; the first stage feeds only the second.
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic meta_ff; // First stage, may go metastable.
		logic nxt_meta;
		logic hold_ff; // Second stage, safe to read.
		logic nxt_hold;

		// Next values are a plain shift.
		always_comb begin
			nxt_meta = async_in[i];
			nxt_hold = meta_ff;
		end

		// Registers clear to low so no false edge is seen after reset.
		always_ff @(posedge core_clk) begin
			if (sys_rst) begin
				meta_ff <= 1'b0;
				hold_ff <= 1'b0;
			end else begin
				meta_ff <= nxt_meta;
				hold_ff <= nxt_hold;
			end
		end

		assign sync_out[i] = hold_ff;
	end

endmodule

// [verilog/cds_clock_ctrl.sv]
`include "cds_params.svh"

module cds_clock_ctrl
	import cds_pkg::*;
#(
	parameter int RATIO_W = 3,
	parameter int WAKE_W = 12
) (
	input wire logic core_clk, // Incoming sample clock, 200 MHz.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire cds_reg_req_t reg_req, // Register port access.
	output logic [7:0] reg_rdata, // Read data, valid the cycle after rd.
	input wire cds_pins_t pins, // Asynchronous sync, SYSREF and power-down pins.
	output logic internal_clk, // Divided and stabilised internal clock.
	output logic sample_tick, // One-cycle pulse on each internal rising edge.
	output logic ser_out_oe, // High while the serial output drivers drive.
	output logic ref_on, // High while the reference and its buffer are powered.
	output logic bias_on, // High while the bias networks are powered.
	output logic clk_on, // High while the internal clock runs.
	output logic conv_ready // High in normal conversion operation.
);

	////////////////////////////////////////////////////////////////////////
	// Elaboration checks: the ratio field is three bits wide for one to eight.
	if (RATIO_W != 3) begin : g_chk_ratio
		$error("cds_clock_ctrl supports RATIO_W of 3 only.");
	end
	if (WAKE_W < 4 || WAKE_W > 12) begin : g_chk_wake
		$error("cds_clock_ctrl supports WAKE_W from 4 to 12.");
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation; nothing reads the raw pins.
	cds_pins_t pins_s; // Pins after two flip-flops.

	cds_sync2 #(
		.WIDTH(3)
	) u_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in(pins),
		.sync_out(pins_s)
	);

	logic sync_prev_ff; // Previous synchronised strobe level.
	logic nxt_sync_prev;
	logic sysref_prev_ff; // Previous synchronised SYSREF level.
	logic nxt_sysref_prev;
	logic sync_rise; // Rising edge of the alignment strobe.
	logic sysref_rise; // Rising edge of SYSREF.

	// Edge detection works on the second synchroniser stage only.
	always_comb begin
		nxt_sync_prev = pins_s.sync_strobe;
		nxt_sysref_prev = pins_s.sysref;
		sync_rise = pins_s.sync_strobe & ~sync_prev_ff;
		sysref_rise = pins_s.sysref & ~sysref_prev_ff;
	end

	// Edge history registers.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sync_prev_ff <= 1'b0;
			sysref_prev_ff <= 1'b0;
		end else begin
			sync_prev_ff <= nxt_sync_prev;
			sysref_prev_ff <= nxt_sysref_prev;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register file.
	logic [7:0] align_ff; // Clock divider alignment control.
	logic [7:0] nxt_align;
	logic [7:0] power_ff; // Power-down and standby commands.
	logic [7:0] nxt_power;
	logic [7:0] stab_ff; // Duty cycle stabilizer enable.
	logic [7:0] nxt_stab;
	logic [7:0] ratio_ff; // Divide ratio minus one.
	logic [7:0] nxt_ratio;
	logic armed_ff; // First-strobe realignment is armed.
	logic nxt_armed;
	logic [7:0] rdata_ff; // Read data register.
	logic [7:0] nxt_rdata;
	logic [7:0] status; // Live status byte.
	logic align_wr; // This cycle writes the alignment register.
	logic strobe_raw; // Edge from the selected reset source.
	logic strobe_valid; // Edge accepted as a divider reset.
	cds_pwr_state_t state_ff; // Power state.
	logic clk_on_ff, nxt_clk_on; // Internal clock runs; strobes need it.
	logic conv_ready_ff, nxt_conv_ready; // Normal operation, also shown in status.

	// Strobe qualification; the pin strobe is dropped under SYSREF source.
	always_comb begin
		if (align_ff[`CDS_ALIGN_SYSREF_BIT]) begin
			strobe_raw = sysref_rise;
		end else begin
			strobe_raw = sync_rise;
		end
		// Once mode only passes a strobe while armed; the clock must run.
		strobe_valid = strobe_raw & align_ff[`CDS_ALIGN_EN_BIT]
			& (~align_ff[`CDS_ALIGN_ONCE_BIT] | armed_ff) & clk_on_ff;
	end

	// Writes, arming and read decode.
	always_comb begin
		nxt_align = align_ff;
		nxt_power = power_ff;
		nxt_stab = stab_ff;
		nxt_ratio = ratio_ff;
		nxt_rdata = rdata_ff;
		align_wr = reg_req.wr && (reg_req.addr == `CDS_ADDR_ALIGN);
		status = `CDS_RDATA_NONE;
		status[`CDS_STAT_ARMED_BIT] = armed_ff;
		status[`CDS_STAT_PD_BIT] = (state_ff == CDS_PWR_DOWN);
		status[`CDS_STAT_STBY_BIT] = (state_ff == CDS_PWR_STBY);
		status[`CDS_STAT_READY_BIT] = conv_ready_ff;
		status[`CDS_STAT_PIN_BIT] = pins_s.powerdown_pin;
		if (reg_req.wr) begin
			if (reg_req.addr == `CDS_ADDR_ALIGN) begin
				nxt_align = reg_req.wdata & `CDS_ALIGN_MASK;
			end else if (reg_req.addr == `CDS_ADDR_POWER) begin
				nxt_power = reg_req.wdata & `CDS_POWER_MASK;
			end else if (reg_req.addr == `CDS_ADDR_STAB) begin
				nxt_stab = reg_req.wdata & `CDS_STAB_MASK;
			end else if (reg_req.addr == `CDS_ADDR_RATIO) begin
				nxt_ratio = reg_req.wdata & `CDS_RATIO_MASK;
			end
		end
		// A strobe spends the arm; a write in the same cycle re-arms and wins.
		nxt_armed = armed_ff;
		if (strobe_valid && align_ff[`CDS_ALIGN_ONCE_BIT]) begin
			nxt_armed = 1'b0;
		end
		if (align_wr) begin
			nxt_armed = 1'b1;
		end
		if (reg_req.rd) begin
			if (reg_req.addr == `CDS_ADDR_ALIGN) begin
				nxt_rdata = align_ff;
			end else if (reg_req.addr == `CDS_ADDR_POWER) begin
				nxt_rdata = power_ff;
			end else if (reg_req.addr == `CDS_ADDR_STAB) begin
				nxt_rdata = stab_ff;
			end else if (reg_req.addr == `CDS_ADDR_RATIO) begin
				nxt_rdata = ratio_ff;
			end else if (reg_req.addr == `CDS_ADDR_STATUS) begin
				nxt_rdata = status;
			end else begin
				nxt_rdata = `CDS_RDATA_NONE; // Unmapped offsets read as zero.
			end
		end
	end

	// Register file flip-flops.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			align_ff <= `CDS_RST_ALIGN;
			power_ff <= `CDS_RST_POWER;
			stab_ff <= `CDS_RST_STAB;
			ratio_ff <= `CDS_RST_RATIO;
			armed_ff <= 1'b0;
			rdata_ff <= `CDS_RDATA_NONE;
		end else begin
			align_ff <= nxt_align;
			power_ff <= nxt_power;
			stab_ff <= nxt_stab;
			ratio_ff <= nxt_ratio;
			armed_ff <= nxt_armed;
			rdata_ff <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power state machine.
	cds_pwr_state_t nxt_state;
	logic [WAKE_W-1:0] down_time_ff; // Time spent down, saturating.
	logic [WAKE_W-1:0] nxt_down_time;
	logic [WAKE_W-1:0] wake_cnt_ff; // Remaining wake-up cycles.
	logic [WAKE_W-1:0] nxt_wake_cnt;
	logic pd_req; // Full power-down is requested.
	logic stby_req; // Standby is requested.
	logic ser_out_oe_ff, nxt_ser_out_oe;
	logic ref_on_ff, nxt_ref_on;
	logic bias_on_ff, nxt_bias_on;

	// Full power-down outranks standby when both are asked for.
	always_comb begin
		pd_req = power_ff[`CDS_POWER_PD_BIT] | pins_s.powerdown_pin;
		stby_req = power_ff[`CDS_POWER_STBY_BIT];
		nxt_state = state_ff;
		nxt_down_time = down_time_ff;
		nxt_wake_cnt = wake_cnt_ff;
		case (state_ff)
			CDS_PWR_RUN: begin
				nxt_down_time = '0;
				if (pd_req) begin
					nxt_state = CDS_PWR_DOWN;
				end else if (stby_req) begin
					nxt_state = CDS_PWR_STBY;
				end
			end
			CDS_PWR_DOWN, CDS_PWR_STBY: begin
				// Discharge accumulates while down; wake time follows it.
				if (down_time_ff != '1) begin
					nxt_down_time = down_time_ff + 1'b1;
				end
				if (pd_req) begin
					nxt_state = CDS_PWR_DOWN;
				end else if (stby_req) begin
					nxt_state = CDS_PWR_STBY;
				end else begin
					nxt_state = CDS_PWR_WAKE;
					if (state_ff == CDS_PWR_STBY) begin
						nxt_wake_cnt = down_time_ff >> `CDS_STBY_WAKE_SHIFT;
					end else begin
						nxt_wake_cnt = down_time_ff;
					end
				end
			end
			CDS_PWR_WAKE: begin
				// Going down again mid-wake keeps the charge still missing.
				if (pd_req || stby_req) begin
					nxt_down_time = wake_cnt_ff;
					nxt_state = pd_req ? CDS_PWR_DOWN : CDS_PWR_STBY;
				end else if (wake_cnt_ff == '0) begin
					nxt_state = CDS_PWR_RUN;
				end else begin
					nxt_wake_cnt = wake_cnt_ff - 1'b1;
				end
			end
			default: begin
				nxt_state = CDS_PWR_RUN;
			end
		endcase
		// Drivers float, and circuits are off, according to the next state.
		nxt_ser_out_oe = (nxt_state == CDS_PWR_RUN);
		nxt_ref_on = (nxt_state != CDS_PWR_DOWN);
		nxt_bias_on = (nxt_state == CDS_PWR_RUN) || (nxt_state == CDS_PWR_WAKE);
		nxt_clk_on = nxt_bias_on;
		nxt_conv_ready = (nxt_state == CDS_PWR_RUN);
	end

	// Power state flip-flops; reset comes up running.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_ff <= CDS_PWR_RUN;
			down_time_ff <= '0;
			wake_cnt_ff <= '0;
			ser_out_oe_ff <= 1'b1;
			ref_on_ff <= 1'b1;
			bias_on_ff <= 1'b1;
			clk_on_ff <= 1'b1;
			conv_ready_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			down_time_ff <= nxt_down_time;
			wake_cnt_ff <= nxt_wake_cnt;
			ser_out_oe_ff <= nxt_ser_out_oe;
			ref_on_ff <= nxt_ref_on;
			bias_on_ff <= nxt_bias_on;
			clk_on_ff <= nxt_clk_on;
			conv_ready_ff <= nxt_conv_ready;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock divider and duty cycle stabilizer.
	logic [RATIO_W-1:0] cnt_ff; // Position within the divided period.
	logic [RATIO_W-1:0] nxt_cnt;
	logic [RATIO_W-1:0] act_ratio_ff; // Ratio minus one in force this period.
	logic [RATIO_W-1:0] nxt_act_ratio;
	logic [RATIO_W:0] half; // High-phase length with the stabilizer on.
	logic int_clk_ff, nxt_int_clk;
	logic tick_ff, nxt_tick;

	// A new ratio takes effect only at a period boundary, avoiding runt pulses.
	always_comb begin
		nxt_act_ratio = act_ratio_ff;
		if (!clk_on_ff) begin
			nxt_cnt = '0;
			nxt_act_ratio = ratio_ff[RATIO_W-1:0];
		end else if (strobe_valid) begin
			nxt_cnt = '0;
			nxt_act_ratio = ratio_ff[RATIO_W-1:0];
		end else if (cnt_ff == act_ratio_ff) begin
			nxt_cnt = '0;
			nxt_act_ratio = ratio_ff[RATIO_W-1:0];
		end else begin
			nxt_cnt = cnt_ff + 1'b1;
		end
		// Ceiling of half the period; the high phase may start only at count zero,
		// so enabling the stabilizer mid-period cannot make a rise without a sample.
		half = ({1'b0, nxt_act_ratio} + 1'b1 + 1'b1) >> 1;
		if (stab_ff[`CDS_STAB_EN_BIT]) begin
			nxt_int_clk = nxt_clk_on & ({1'b0, nxt_cnt} < half)
				& (int_clk_ff | (nxt_cnt == '0));
		end else begin
			nxt_int_clk = nxt_clk_on & (nxt_cnt == '0);
		end
		nxt_tick = nxt_clk_on & (nxt_cnt == '0);
	end

	// Divider flip-flops.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt_ff <= '0;
			act_ratio_ff <= '0;
			int_clk_ff <= 1'b0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			act_ratio_ff <= nxt_act_ratio;
			int_clk_ff <= nxt_int_clk;
			tick_ff <= nxt_tick;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flip-flops.
	assign reg_rdata = rdata_ff;
	assign internal_clk = int_clk_ff;
	assign sample_tick = tick_ff;
	assign ser_out_oe = ser_out_oe_ff;
	assign ref_on = ref_on_ff;
	assign bias_on = bias_on_ff;
	assign clk_on = clk_on_ff;
	assign conv_ready = conv_ready_ff;

endmodule

// [testbench/cds_clock_ctrl_monitor.sv]
`include "cds_params.svh"
module cds_clock_ctrl_monitor
	import cds_pkg::*;
#(
	parameter int RATIO_W = 3,
	parameter int WAKE_W = 12
) (
	input wire logic core_clk, // Sample clock.
	input wire logic sys_rst, // Synchronous reset.
	input wire cds_reg_req_t reg_req, // Register access.
	input wire logic [7:0] reg_rdata, // Read data.
	input wire cds_pins_t pins, // Control pins.
	input wire logic internal_clk, // Divided clock.
	input wire logic sample_tick, // Rising edge pulse.
	input wire logic ser_out_oe, // Output drive enable.
	input wire logic ref_on, // Reference power.
	input wire logic bias_on, // Bias power.
	input wire logic clk_on, // Clock running.
	input wire logic conv_ready // Normal operation.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] align_ff; // Shadow of the alignment register.
	logic [7:0] nxt_align; // Its next value.
	logic [1:0] pwr_ff; // Shadow of the power command bits.
	logic [1:0] nxt_pwr; // Its next value.
	////////////////////////////////////////
	// Follow writes so the checks know the mode in force.
	always_comb begin
		nxt_align = align_ff;
		nxt_pwr = pwr_ff;
		if (sys_rst) begin
			nxt_align = `CDS_RST_ALIGN;
			nxt_pwr = 2'h0;
		end else if (reg_req.wr && reg_req.addr == `CDS_ADDR_ALIGN) begin
			nxt_align = reg_req.wdata & `CDS_ALIGN_MASK;
		end else if (reg_req.wr && reg_req.addr == `CDS_ADDR_POWER) begin
			nxt_pwr = reg_req.wdata[1:0];
		end
	end
	// Register the shadows.
	always_ff @(posedge core_clk) begin
		align_ff <= nxt_align;
		pwr_ff <= nxt_pwr;
	end
	////////////////////////////////////////
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_align_readback: assert property (
		reg_req.rd && !reg_req.wr && reg_req.addr == `CDS_ADDR_ALIGN |=> reg_rdata == align_ff)
		else $error("alignment read back differs");
	a_sysref_realign: assert property (
		$rose(pins.sysref) && align_ff[`CDS_ALIGN_SYSREF_BIT] && align_ff[`CDS_ALIGN_EN_BIT]
		&& !align_ff[`CDS_ALIGN_ONCE_BIT] && clk_on |-> ##[2:6] sample_tick)
		else $error("no realign on sysref");
	a_reg_pd_enter: assert property (
		reg_req.wr && reg_req.addr == `CDS_ADDR_POWER && reg_req.wdata[0] |-> ##[1:2] !clk_on)
		else $error("register power-down not taken");
	a_pin_pd_enter: assert property (
		pins.powerdown_pin [*6] |-> !clk_on && !ref_on)
		else $error("pin power-down not taken");
	a_pin_wake: assert property (
		(!pins.powerdown_pin && pwr_ff == 2'h0) [*6] |-> bias_on && clk_on)
		else $error("no wake with pin low");
	a_oe_gated: assert property (
		ser_out_oe |-> conv_ready && clk_on && bias_on && ref_on)
		else $error("outputs driven while not running");
	a_down_quiet: assert property (
		!clk_on |-> !bias_on && !sample_tick && !conv_ready)
		else $error("activity while clock off");
	a_wake_not_ready: assert property (
		$rose(bias_on) |-> !conv_ready)
		else $error("ready without wake time");
	a_stby_ref_kept: assert property (
		(pwr_ff == 2'h2 && !pins.powerdown_pin) [*4] |-> ref_on && !clk_on)
		else $error("standby state wrong");
	a_tick_on_rise: assert property (
		$rose(internal_clk) |-> sample_tick)
		else $error("rising edge without tick");
	a_tick_spacing: assert property (
		sample_tick |-> ##[1:8] (sample_tick || !conv_ready))
		else $error("divide ratio above eight");
endmodule

bind cds_clock_ctrl cds_clock_ctrl_monitor #(.RATIO_W(RATIO_W), .WAKE_W(WAKE_W))
	u_cds_clock_ctrl_monitor (.core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req),
	.reg_rdata(reg_rdata), .pins(pins), .internal_clk(internal_clk),
	.sample_tick(sample_tick), .ser_out_oe(ser_out_oe), .ref_on(ref_on),
	.bias_on(bias_on), .clk_on(clk_on), .conv_ready(conv_ready));

// [testbench/cds_far_model.sv]
module cds_far_model
	import cds_pkg::*;
(
	input wire logic core_clk, // Sample clock from the generator.
	output cds_pins_t pins // Strobe, SYSREF and power-down levels.
);
	timeunit 1ns;
	timeprecision 1ps;
	int hold_cnt; // Cycles left on the current strobe.
	////////////////////////////////////////
	// The clock rate never steps here, so the relock wait is met trivially.
	initial begin
		pins = '0;
		hold_cnt = 0;
	end
	// Raise the strobe (0) or SYSREF (1) now; held long enough to pass the synchroniser.
	task pulse(input int sel);
		if (sel == 0) pins.sync_strobe = 1'b1;
		else pins.sysref = 1'b1;
		hold_cnt = 4;
	endtask
	// Drive the power-down pin level.
	task set_pd(input logic lvl);
		pins.powerdown_pin = lvl;
	endtask
	// Drop both strobes once held, so the next one gives a fresh rising edge.
	always @(negedge core_clk) begin
		if (hold_cnt > 0) hold_cnt--;
		else begin
			pins.sync_strobe = 1'b0;
			pins.sysref = 1'b0;
		end
	end
endmodule

// [testbench/tb_top.sv]
`include "cds_params.svh"
module tb_top;
	import cds_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk; // Sample clock.
	logic sys_rst; // Reset.
	cds_reg_req_t reg_req; // Register access.
	logic [7:0] reg_rdata; // Read data.
	cds_pins_t pins; // Driven by the far side model.
	logic internal_clk, sample_tick, ser_out_oe, ref_on, bias_on, clk_on, conv_ready;
	int num_errors, samples_checked, wa, wb, wc, wd, d;
	// Strobe table: alignment value, source (1 = SYSREF), realign expected, write first.
	logic [7:0] s_al [9] = '{8'h01, 8'h01, 8'h03, 8'h03, 8'h03, 8'h81, 8'h81, 8'h01, 8'h00};
	int s_sel [9] = '{0, 0, 0, 0, 0, 0, 1, 1, 0};
	bit s_exp [9] = '{1, 1, 1, 0, 1, 0, 1, 0, 0};
	bit s_wr [9] = '{1, 0, 1, 0, 1, 1, 0, 1, 1};
	////////////////////////////////////////
	// Short wake counter keeps power cycles brief.
	cds_clock_ctrl #(.RATIO_W(3), .WAKE_W(4)) u_cds_clock_ctrl (.core_clk(core_clk),
		.sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .pins(pins),
		.internal_clk(internal_clk), .sample_tick(sample_tick), .ser_out_oe(ser_out_oe),
		.ref_on(ref_on), .bias_on(bias_on), .clk_on(clk_on), .conv_ready(conv_ready));
	cds_far_model u_cds_far_model (.core_clk(core_clk), .pins(pins));
	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;
	////////////////////////////////////////
	// Compare and count.
	task check_val(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One write strobe; the trailing edge keeps back-to-back calls apart.
	task reg_wr(input logic [12:0] a, input logic [7:0] v);
		reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = v;
		@(negedge core_clk);
		reg_req.wr = 1'b0;
		@(negedge core_clk);
	endtask
	// Read data is valid one cycle after the strobe edge.
	task reg_rd(input logic [12:0] a, input logic [7:0] exp);
		reg_req.rd = 1'b1;
		reg_req.addr = a;
		@(negedge core_clk);
		reg_req.rd = 1'b0;
		@(negedge core_clk);
		check_val(reg_rdata, exp);
	endtask
	// Stop at the first falling edge that shows a tick.
	task wait_tick;
		int k;
		k = 0;
		while (sample_tick !== 1'b1 && k < 20) begin
			@(negedge core_clk);
			k++;
		end
	endtask
	// Measure tick period and high time of the internal clock.
	task meas(input int n, input logic [7:0] stab);
		int k;
		logic [7:0] hi;
		reg_wr(`CDS_ADDR_STAB, stab);
		reg_wr(`CDS_ADDR_RATIO, 8'(n - 1));
		repeat (20) @(negedge core_clk);
		wait_tick();
		k = 0;
		hi = 8'h00;
		do begin
			hi = hi + {7'h00, internal_clk};
			@(negedge core_clk);
			k++;
		end while (sample_tick !== 1'b1 && k < 20);
		check_val(8'(k), 8'(n));
		check_val(hi, stab[0] ? 8'((n + 1) / 2) : 8'h01);
	endtask
	// Power down by pin (0), register (1) or standby (2); return the wake length.
	task pw(input int how, input int hold, output int wl);
		if (how == 0) u_cds_far_model.set_pd(1'b1);
		else reg_wr(`CDS_ADDR_POWER, how == 1 ? 8'h01 : 8'h02);
		repeat (hold) @(negedge core_clk);
		check_val({3'h0, ref_on, bias_on, clk_on, ser_out_oe, conv_ready},
			how == 2 ? 8'h10 : 8'h00);
		if (how == 0) u_cds_far_model.set_pd(1'b0);
		else reg_wr(`CDS_ADDR_POWER, 8'h00);
		wl = 0;
		while (conv_ready !== 1'b1 && wl < 100) begin
			@(negedge core_clk);
			wl++;
		end
		check_val({4'h0, ref_on, bias_on, clk_on, ser_out_oe}, 8'h0F);
	endtask
	// Verdict and end of run.
	task tally_and_finish;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	////////////////////////////////////////
	// The whole sequence needs under a thousand cycles.
	initial begin
		#100000;
		num_errors++;
		tally_and_finish();
	end
	// Main sequence.
	initial begin
		num_errors = 0;
		samples_checked = 0;
		sys_rst = 1'b1;
		reg_req = '0;
		repeat (10) @(negedge core_clk);
		sys_rst = 1'b0;
		check_val({3'h0, ref_on, bias_on, clk_on, ser_out_oe, conv_ready}, 8'h1F);
		reg_rd(`CDS_ADDR_ALIGN, `CDS_RST_ALIGN);
		reg_rd(`CDS_ADDR_POWER, 8'h00);
		reg_rd(`CDS_ADDR_STAB, 8'h01);
		reg_wr(`CDS_ADDR_ALIGN, 8'hFF);
		reg_rd(`CDS_ADDR_ALIGN, 8'h83);
		reg_rd(`CDS_ADDR_STATUS, 8'h09);
		reg_wr(`CDS_ADDR_RATIO, 8'hFF);
		reg_rd(`CDS_ADDR_RATIO, 8'h07);
		reg_wr(13'h1FF, 8'h5A);
		reg_rd(13'h1FF, 8'h00);
		meas(5, 8'h00);
		for (int n = 1; n <= 8; n++) meas(n, 8'h01);
		// Strobe right at a tick: a realign gives the next tick three cycles on, not eight.
		for (int i = 0; i < 9; i++) begin
			if (s_wr[i]) reg_wr(`CDS_ADDR_ALIGN, s_al[i]);
			repeat (12) @(negedge core_clk);
			wait_tick();
			u_cds_far_model.pulse(s_sel[i]);
			d = 0;
			do begin
				@(negedge core_clk);
				d++;
			end while (sample_tick !== 1'b1 && d < 12);
			check_val({7'h00, d < 7}, {7'h00, s_exp[i]});
		end
		pw(0, 20, wa);
		pw(1, 20, wb);
		pw(1, 6, wc);
		pw(2, 20, wd);
		check_val({7'h00, wc < wb}, 8'h01);
		check_val({7'h00, wd < wb}, 8'h01);
		tally_and_finish();
	end
endmodule
